// *** core/fcd_host.sv ***
// host controller that issues flash command sequences on the pins
// Behaviour
// - unlock and command addresses carry 555h/2AAh on the low eleven lines
// - program: two unlocks, A0h to 555h, then value at target
// - chip erase: unlocks, 80h, unlocks, 10h to 555h
// - sector erase: same five writes, then 30h at sector address
// - erase suspend is one write of B0h anywhere
// - erase resume is one write of 30h anywhere
// - identifier mode: two unlocks then 90h to 555h
// - protect unlock: five erase writes then 20h to 555h
// - unlock sequence must precede low-voltage protect pulse
// - low-voltage verify read only right after a protect pulse (code instead refuses low-voltage reads with line one low right after a pulse)
// - low-voltage protect: ce low, oe high, we low, detect line high
// - elevated protect: oe and detect line elevated, we low
// - F0h aborts a failed operation and returns to read
// - address taken on falling strobe, data on rising strobe
// - each extra sector write must start within 30us
`default_nettype none
module fcd_host
   import fcd_pkg::*;
(
   input  wire logic              core_clk_i,
   input  wire logic              srst_i,
   input  wire logic [REG_AW-1:0] reg_addr_i,
   input  wire logic [REG_DW-1:0] reg_wdata_i,
   input  wire logic              reg_wr_i,
   input  wire logic              reg_rd_i,
   output logic      [REG_DW-1:0] reg_rdata_o,
   output logic                   flash_ce_n_o,
   output logic                   flash_oe_n_o,
   output logic                   flash_we_n_o,
   output logic                   flash_oe_hv_o,
   output logic                   flash_hv_addr_o,
   output logic      [ADDR_W-1:0] flash_addr_o,
   output logic      [DATA_W-1:0] flash_dq_o,
   output logic                   flash_dq_oe_o,
   input  wire logic [DATA_W-1:0] flash_dq_i
);

   typedef struct packed {
      fcd_state_e        st;
      fcd_op_e           op;
      logic [2:0]        step;
      logic [CNT_W-1:0]  cnt;
      logic [CNT_W-1:0]  gap;
      logic              gap_run;
      logic              busy;
      logic              late;
      logic              prot_unl;
      logic              prot_done;
      logic              refused;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] wdata;
      logic [DATA_W-1:0] rdata;
      logic [2:0]        hvcfg;
      logic [DATA_W-1:0] dq_s1;
      logic [DATA_W-1:0] dq_s2;
      fcd_pins_s         pins;
      logic [REG_DW-1:0] rd_out;
   } fcd_host_s;

   fcd_host_s r;
   fcd_host_s next_r;
   fcd_cyc_s  cyc;
   logic [2:0] nsteps;

   ////////////////////////////////////////////////////////////////////
   // sequence table: cycle 'step' of operation 'op'
   always_comb begin
      cyc    = '{wr: 1'b1, addr: '0, data: '0};
      nsteps = 3'd1;
      case (r.op)
         FCD_OP_RESET: begin
            // abort and back to array read
            cyc.data = CMD_RESET;
         end
         FCD_OP_READ: begin
            cyc = '{wr: 1'b0, addr: r.addr, data: '0};
         end
         FCD_OP_SUSPEND: begin
            // single write of B0h, any address
            cyc = '{wr: 1'b1, addr: r.addr, data: CMD_SUSPEND};
         end
         FCD_OP_RESUME: begin
            cyc = '{wr: 1'b1, addr: r.addr, data: CMD_RESUME};
         end
         FCD_OP_SECT_ADD: begin
            // further sector in the load window
            cyc = '{wr: 1'b1, addr: r.addr, data: CMD_SECT_ER};
         end
         FCD_OP_PROT_PULSE,
         FCD_OP_HV_PULSE: begin
            // we pulse with protect select on its line
            cyc = '{wr: 1'b1, addr: r.addr, data: '0};
         end
         default: begin
            // exact unlock prefix on the low eleven lines, upper lines zero
            nsteps = 3'd4;
            if (r.step == 3'd0 || r.step == 3'd3) begin
               cyc.addr = {{(ADDR_W-11){1'b0}}, UNLOCK_ADDR1};
               cyc.data = UNLOCK_DATA1;
            end else if (r.step == 3'd1 || r.step == 3'd4) begin
               cyc.addr = {{(ADDR_W-11){1'b0}}, UNLOCK_ADDR2};
               cyc.data = UNLOCK_DATA2;
            end else begin
               cyc.addr = {{(ADDR_W-11){1'b0}}, UNLOCK_ADDR1};
            end
            case (r.op)
               FCD_OP_PROGRAM: begin
                  // A0h then value at the full target address
                  if (r.step == 3'd2) cyc.data = CMD_PROGRAM;
                  if (r.step == 3'd3) begin
                     cyc.addr = r.addr;
                     cyc.data = r.wdata;
                  end
               end
               FCD_OP_ID_ENTER: begin
                  nsteps = 3'd3;
                  if (r.step == 3'd2) cyc.data = CMD_ID;
               end
               default: begin
                  // six writes sharing the 80h set-up
                  nsteps = 3'd6;
                  if (r.step == 3'd2) cyc.data = CMD_ERASE_SU;
                  if (r.step == 3'd5) begin
                     if (r.op == FCD_OP_CHIP_ERASE) begin
                        cyc.data = CMD_CHIP_ER;
                     end else if (r.op == FCD_OP_PROT_UNLOCK) begin
                        cyc.data = CMD_PROT_UL;
                     end else begin
                        // sector write keeps the full address
                        cyc.addr = r.addr;
                        cyc.data = CMD_SECT_ER;
                     end
                  end
               end
            endcase
         end
      endcase
   end

   ////////////////////////////////////////////////////////////////////
   always_comb begin
      next_r         = r;
      next_r.dq_s1   = flash_dq_i;
      next_r.dq_s2   = r.dq_s1;
      next_r.rd_out  = '0;
      // sector load window timer, runs after each sector write
      if (r.gap_run && r.gap != CNT_W'(T_SLOAD_CYC)) next_r.gap = r.gap + 1'b1;

      // register reads
      if (reg_rd_i) begin
         if (reg_addr_i == REG_ADDR) begin
            next_r.rd_out = REG_DW'(r.addr);
         end else if (reg_addr_i == REG_WDATA) begin
            next_r.rd_out = REG_DW'(r.wdata);
         end else if (reg_addr_i == REG_STATUS) begin
            next_r.rd_out = REG_DW'({r.refused, r.late, r.prot_done, r.prot_unl, r.busy});
         end else if (reg_addr_i == REG_RDATA) begin
            next_r.rd_out = REG_DW'(r.rdata);
         end else if (reg_addr_i == REG_PINS) begin
            next_r.rd_out = REG_DW'(r.hvcfg);
         end else begin
            next_r.rd_out = '0;
         end
      end

      // register writes
      if (reg_wr_i) begin
         if (reg_addr_i == REG_ADDR) begin
            next_r.addr = reg_wdata_i[ADDR_W-1:0];
         end else if (reg_addr_i == REG_WDATA) begin
            next_r.wdata = reg_wdata_i[DATA_W-1:0];
         end else if (reg_addr_i == REG_PINS && !r.busy) begin
            next_r.hvcfg = reg_wdata_i[2:0];
         end else if (reg_addr_i == REG_CTRL) begin
            next_r.refused = 1'b0;
            // one order at a time, busy refuses
            if (r.busy || reg_wdata_i[CTRL_OP_W-1:0] == 4'h0) begin
               next_r.refused = 1'b1;
            end else if (fcd_op_e'(reg_wdata_i[CTRL_OP_W-1:0]) == FCD_OP_SECT_ADD
                         && (!r.gap_run || r.gap == CNT_W'(T_SLOAD_CYC))) begin
               // too late for another sector: refuse, flag late
               next_r.refused = 1'b1;
               next_r.late    = 1'b1;
            end else if (fcd_op_e'(reg_wdata_i[CTRL_OP_W-1:0]) == FCD_OP_PROT_PULSE
                         && !r.prot_unl) begin
               // no low-voltage pulse before the unlock sequence
               next_r.refused = 1'b1;
            end else if (fcd_op_e'(reg_wdata_i[CTRL_OP_W-1:0]) == FCD_OP_READ
                         && r.hvcfg == 3'h0 && r.prot_done && !r.addr[1]) begin
               // verify read after pulse must use line one high
               next_r.refused = 1'b1;
            end else begin
               next_r.op   = fcd_op_e'(reg_wdata_i[CTRL_OP_W-1:0]);
               next_r.busy = 1'b1;
               next_r.step = '0;
               next_r.cnt  = '0;
               next_r.st   = FCD_SETUP;
               next_r.late = 1'b0;
            end
         end
      end

      // pin sequencer: setup, strobe low, hold
      case (r.st)
         FCD_IDLE: begin
            next_r.pins.ce_n  = 1'b1;
            next_r.pins.oe_n  = 1'b1;
            next_r.pins.we_n  = 1'b1;
            next_r.pins.dq_oe = 1'b0;
            next_r.pins.oe_hv = 1'b0;
            next_r.pins.hv_addr = 1'b0;
         end
         FCD_SETUP: begin
            next_r.pins.ce_n    = 1'b0;
            next_r.pins.addr    = cyc.addr;
            next_r.pins.oe_n    = 1'b1;
            next_r.pins.dq_oe   = 1'b0;
            // detect line elevated for pin-level id read
            next_r.pins.hv_addr = r.hvcfg[PIN_HV_ADDR];
            if (r.op == FCD_OP_PROT_PULSE) begin
               // detect line at logic high, select line chooses
               next_r.pins.hv_addr = 1'b1;
               next_r.pins.addr[PIN_PSEL_ADDR] = r.hvcfg[PIN_PSEL];
            end else if (r.op == FCD_OP_HV_PULSE) begin
               // elevated on output drive and detect line
               next_r.pins.oe_hv   = 1'b1;
               next_r.pins.hv_addr = 1'b1;
               next_r.pins.addr[PIN_PSEL_ADDR] = r.hvcfg[PIN_PSEL];
            end
            next_r.cnt = r.cnt + 1'b1;
            // first setup cycle only loads the pins, so one more count
            if (r.cnt == CNT_W'(T_SETUP_CYC)) begin
               next_r.cnt = '0;
               next_r.st  = FCD_PULSE;
               if (cyc.wr) begin
                  // falling strobe after address is stable
                  next_r.pins.we_n  = 1'b0;
                  next_r.pins.dq_o  = cyc.data;
                  next_r.pins.dq_oe = 1'b1;
               end else begin
                  next_r.pins.oe_n = 1'b0;
               end
            end
         end
         FCD_PULSE: begin
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == CNT_W'(T_PULSE_CYC - 1)) begin
               next_r.cnt = '0;
               next_r.st  = FCD_HOLD;
               // rising strobe with data still driven
               next_r.pins.we_n = 1'b1;
               if (!cyc.wr) next_r.rdata = r.dq_s2;
               next_r.pins.oe_n = 1'b1;
            end
         end
         FCD_HOLD: begin
            next_r.cnt = r.cnt + 1'b1;
            if (r.cnt == CNT_W'(T_HOLD_CYC - 1)) begin
               next_r.cnt          = '0;
               next_r.pins.dq_oe   = 1'b0;
               next_r.pins.oe_hv   = 1'b0;
               next_r.st           = FCD_NEXT;
            end
         end
         default: begin
            if (r.step == nsteps - 3'd1) begin
               next_r.st   = FCD_IDLE;
               next_r.busy = 1'b0;
               next_r.pins.ce_n = 1'b1;
               // window opens as the sequence ends, after the last hold phase
               next_r.gap_run = (r.op == FCD_OP_SECT_ERASE || r.op == FCD_OP_SECT_ADD);
               next_r.gap     = '0;
               // unlock good for the next order only
               next_r.prot_unl  = (r.op == FCD_OP_PROT_UNLOCK);
               // verify allowed right after a pulse
               next_r.prot_done = (r.op == FCD_OP_PROT_PULSE);
            end else begin
               next_r.step = r.step + 3'd1;
               next_r.st   = FCD_SETUP;
            end
         end
      endcase
   end

   always_ff @(posedge core_clk_i) begin
      if (srst_i) begin
         r <= '0;
         r.st <= FCD_IDLE;
         r.op <= FCD_OP_NONE;
         r.pins.ce_n <= 1'b1;
         r.pins.oe_n <= 1'b1;
         r.pins.we_n <= 1'b1;
      end else begin
         r <= next_r;
      end
   end

   assign reg_rdata_o     = r.rd_out;
   assign flash_ce_n_o    = r.pins.ce_n;
   assign flash_oe_n_o    = r.pins.oe_n;
   assign flash_we_n_o    = r.pins.we_n;
   assign flash_oe_hv_o   = r.pins.oe_hv;
   assign flash_hv_addr_o = r.pins.hv_addr;
   assign flash_addr_o    = r.pins.addr;
   assign flash_dq_o      = r.pins.dq_o;
   assign flash_dq_oe_o   = r.pins.dq_oe;
endmodule : fcd_host
`default_nettype wire

// *** core/fcd_pkg.sv ***
// package for the flash command host controller
`default_nettype none
package fcd_pkg;
   localparam int unsigned ADDR_W       = 18;
   localparam int unsigned DATA_W       = 8;
   localparam int unsigned CLK_PERIOD_NS = 10;
   // pin cycle phase lengths (least times, in ns)
   localparam int unsigned T_SETUP_NS   = 30;
   localparam int unsigned T_PULSE_NS   = 50;
   localparam int unsigned T_HOLD_NS    = 30;
   localparam int unsigned T_SETUP_CYC  = (T_SETUP_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned T_PULSE_CYC  = (T_PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   localparam int unsigned T_HOLD_CYC   = (T_HOLD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;
   // sector load window: longest gap, rounds down
   localparam int unsigned T_SLOAD_NS   = 30000;
   localparam int unsigned T_SLOAD_CYC  = T_SLOAD_NS / CLK_PERIOD_NS;
   localparam int unsigned CNT_W        = 12;

   localparam logic [10:0] UNLOCK_ADDR1 = 11'h555;
   localparam logic [10:0] UNLOCK_ADDR2 = 11'h2AA;
   localparam logic [7:0]  UNLOCK_DATA1 = 8'hAA;
   localparam logic [7:0]  UNLOCK_DATA2 = 8'h55;
   localparam logic [7:0]  CMD_RESET    = 8'hF0;
   localparam logic [7:0]  CMD_PROGRAM  = 8'hA0;
   localparam logic [7:0]  CMD_ERASE_SU = 8'h80;
   localparam logic [7:0]  CMD_CHIP_ER  = 8'h10;
   localparam logic [7:0]  CMD_SECT_ER  = 8'h30;
   localparam logic [7:0]  CMD_RESUME   = 8'h30;
   localparam logic [7:0]  CMD_SUSPEND  = 8'hB0;
   localparam logic [7:0]  CMD_ID       = 8'h90;
   localparam logic [7:0]  CMD_PROT_UL  = 8'h20;

   // host register map
   localparam logic [3:0] REG_CTRL   = 4'h0;
   localparam logic [3:0] REG_ADDR   = 4'h1;
   localparam logic [3:0] REG_WDATA  = 4'h2;
   localparam logic [3:0] REG_STATUS = 4'h3;
   localparam logic [3:0] REG_RDATA  = 4'h4;
   localparam logic [3:0] REG_PINS   = 4'h5;
   localparam int unsigned REG_AW    = 4;
   localparam int unsigned REG_DW    = 32;

   // ctrl: [3:0] operation, written value starts it
   localparam int unsigned CTRL_OP_W  = 4;
   // pins reg bits
   localparam int unsigned PIN_HV_ADDR = 0;
   localparam int unsigned PIN_HV_OE   = 1;
   localparam int unsigned PIN_PSEL    = 2;
   // address line that selects protect or unprotect during a pulse
   localparam int unsigned PIN_PSEL_ADDR = 6;

   typedef enum logic [3:0] {
      FCD_OP_NONE, FCD_OP_RESET, FCD_OP_READ, FCD_OP_PROGRAM, FCD_OP_CHIP_ERASE,
      FCD_OP_SECT_ERASE, FCD_OP_SECT_ADD, FCD_OP_SUSPEND, FCD_OP_RESUME,
      FCD_OP_ID_ENTER, FCD_OP_PROT_UNLOCK, FCD_OP_PROT_PULSE, FCD_OP_HV_PULSE
   } fcd_op_e;

   typedef enum logic [2:0] {
      FCD_IDLE, FCD_SETUP, FCD_PULSE, FCD_HOLD, FCD_NEXT
   } fcd_state_e;

   // one flash pin cycle
   typedef struct packed {
      logic              wr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] data;
   } fcd_cyc_s;

   // flash side pins driven by the host
   typedef struct packed {
      logic              ce_n;
      logic              oe_n;
      logic              we_n;
      logic              oe_hv;
      logic              hv_addr;
      logic [ADDR_W-1:0] addr;
      logic [DATA_W-1:0] dq_o;
      logic              dq_oe;
   } fcd_pins_s;
endpackage : fcd_pkg
`default_nettype wire

// *** testbench/fcd_flash_model.sv ***
// behavioural model of the flash command decoder
`default_nettype none
module fcd_flash_model
   import fcd_pkg::*;
#(
   parameter logic [7:0] MAKER_ID = 8'h3C, // arbitrary value
   parameter logic [7:0] DEV_ID   = 8'h4D  // arbitrary value
)(
   input  wire logic              ce_n_i,
   input  wire logic              oe_n_i,
   input  wire logic              we_n_i,
   input  wire logic              oe_hv_i,
   input  wire logic              hv_addr_i,
   input  wire logic [ADDR_W-1:0] addr_i,
   input  wire logic [DATA_W-1:0] dq_i,
   output logic      [DATA_W-1:0] dq_o,
   output logic      [7:0]        cmd_o,
   output logic      [ADDR_W-1:0] cadr_o,
   output logic      [7:0]        bad_o,
   output logic                   prot_o
);
   timeunit 1ns;
   timeprecision 1ps;
   logic [ADDR_W-1:0] alat;
   logic [10:0]       lo;
   logic [3:0]        st;
   logic              unl, idm;
   logic [7:0]        mem [16];
   logic [7:0]        rd, last;
   wire               drv = !ce_n_i && !oe_n_i;
   initial begin
      st = 4'h0;
      unl = 1'b0;
      idm = 1'b0;
      bad_o = 8'h00;
      prot_o = 1'b0;
      last = 8'h00;
      foreach (mem[i]) mem[i] = 8'hFF;
   end
   task automatic note(input logic [7:0] d);
      cmd_o = d;
      cadr_o = alat;
      st = 4'h0;
      if (d == 8'hF0) begin
         idm = 1'b0;
      end
   endtask : note
   task automatic fail();
      bad_o = bad_o + 8'h01;
      st = 4'h0;
   endtask : fail
////////////////////////////////////////////////////////////
   // address on falling strobe, data on rising strobe
   always @(negedge we_n_i) begin
      if (!ce_n_i) begin
         alat = addr_i;
      end
   end
   always @(posedge we_n_i) begin
      lo = alat[10:0];
      if (!ce_n_i && hv_addr_i) begin
         // pulse acts after unlock or with elevated drive
         if (oe_hv_i || unl) begin
            prot_o = !alat[6];
         end
         unl = 1'b0;
      end else if (!ce_n_i) begin
         unl = 1'b0;
         // unlock writes matched on the low eleven lines only
         case (st)
            4'h0, 4'h3: begin
               if (dq_i == 8'hAA && lo == 11'h555) begin
                  st = st + 4'h1;
               end else if (st == 4'h0) begin
                  note(dq_i);
               end else begin
                  fail();
               end
            end
            4'h1, 4'h4: begin
               if (dq_i == 8'h55 && lo == 11'h2AA) begin
                  st = st + 4'h1;
               end else begin
                  fail();
               end
            end
            4'h2: begin
               if (lo != 11'h555 || !(dq_i inside {8'hA0, 8'h80, 8'h90})) begin
                  fail();
               end else begin
                  st = dq_i == 8'hA0 ? 4'h6 : 4'h3;
                  if (dq_i == 8'h90) begin
                     note(dq_i);
                     idm = 1'b1;
                  end
               end
            end
            4'h5: begin
               // sixth write, sector code at sector address
               if (dq_i == 8'h30 || (lo == 11'h555 && dq_i inside {8'h10, 8'h20})) begin
                  note(dq_i);
                  unl = dq_i == 8'h20;
               end else begin
                  fail();
               end
            end
            default: begin
               // program value stored by the low four target address lines
               mem[alat[3:0]] = dq_i;
               note(8'hA0);
            end
         endcase
      end
   end
   // identifier and protect codes, else array data
   always @* begin
      if ((idm || hv_addr_i) && addr_i[1]) begin
         rd = {7'h00, prot_o};
      end else if (idm || hv_addr_i) begin
         rd = addr_i[0] ? DEV_ID : MAKER_ID;
      end else begin
         rd = mem[addr_i[3:0]];
      end
   end
   // released pins show no stale value
   always @(drv or rd) begin
      if (drv) begin
         last = rd;
      end
   end
   assign dq_o = drv ? rd : ~last;
endmodule : fcd_flash_model
`default_nettype wire

// *** testbench/fcd_host_asserts.sv ***
// pin-level and register read-data assertions for the flash command host
`default_nettype none
module fcd_host_asserts
   import fcd_pkg::*;
(
   input wire logic              core_clk_i,
   input wire logic              srst_i,
   input wire logic              reg_rd_i,
   input wire logic [REG_DW-1:0] reg_rdata_o,
   input wire logic              flash_ce_n_o,
   input wire logic              flash_oe_n_o,
   input wire logic              flash_we_n_o,
   input wire logic              flash_oe_hv_o,
   input wire logic              flash_hv_addr_o,
   input wire logic [ADDR_W-1:0] flash_addr_o,
   input wire logic [DATA_W-1:0] flash_dq_o,
   input wire logic              flash_dq_oe_o
);
   timeunit 1ns;
   timeprecision 1ps;
   default clocking @(posedge core_clk_i);
   endclocking
   default disable iff (srst_i);
////////////////////////////////////////////////////////////
   a_reset_idle: assert property (
      $past(srst_i) |-> flash_ce_n_o && flash_oe_n_o && flash_we_n_o && !flash_dq_oe_o)
      else $error("pins not idle after reset");
   a_no_contend: assert property (
      flash_dq_oe_o |-> flash_oe_n_o)
      else $error("host drives data while device output is on");
   a_write_ce: assert property (
      !flash_we_n_o |-> !flash_ce_n_o)
      else $error("write strobe without chip select");
   a_we_width: assert property (
      $fell(flash_we_n_o) |-> (!flash_we_n_o)[*5] ##1 flash_we_n_o)
      else $error("write strobe width wrong");
   a_addr_setup: assert property (
      $fell(flash_we_n_o) |-> $past(flash_ce_n_o, 3) == 1'b0
         && $past(flash_addr_o, 3) == flash_addr_o)
      else $error("address setup too short");
   a_data_hold: assert property (
      $rose(flash_we_n_o) && flash_dq_oe_o
         |-> (flash_dq_oe_o && $stable(flash_dq_o) && $stable(flash_addr_o))[*3])
      else $error("data or address not held after strobe");
   a_pulse_oe: assert property (
      !flash_we_n_o && !flash_oe_hv_o |-> flash_oe_n_o)
      else $error("output drive low during write");
   a_hv_pair: assert property (
      flash_oe_hv_o |-> flash_hv_addr_o)
      else $error("elevated drive without elevated detect line");
   a_rdata_slot: assert property (
      reg_rdata_o != '0 |-> $past(reg_rd_i))
      else $error("read data outside its slot");
endmodule : fcd_host_asserts
bind fcd_host fcd_host_asserts i_fcd_host_asserts (.core_clk_i, .srst_i, .reg_rd_i,
   .reg_rdata_o, .flash_ce_n_o, .flash_oe_n_o, .flash_we_n_o, .flash_oe_hv_o,
   .flash_hv_addr_o, .flash_addr_o, .flash_dq_o, .flash_dq_oe_o);
`default_nettype wire

// *** testbench/tb_top.sv ***
// self-checking bench for the flash command host
`default_nettype none
module tb_top
   import fcd_pkg::*;
;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] MAKER_ID = 8'h3C; // arbitrary value
   localparam logic [7:0] DEV_ID   = 8'h4D; // arbitrary value
   typedef struct packed {
      logic [3:0]        op;
      logic [ADDR_W-1:0] a;
      logic [7:0]        d;
      logic [7:0]        exp;
      logic              ca;
   } fcd_row_s;
   logic              core_clk, srst, reg_wr, reg_rd, ce_n, oe_n, we_n, oe_hv, hv, dq_oe, prot;
   logic [REG_AW-1:0] reg_addr;
   logic [REG_DW-1:0] reg_wdata, reg_rdata, v;
   logic [ADDR_W-1:0] addr, cadr;
   logic [DATA_W-1:0] dq_h, dq_f, cmd, bad;
   wire  [DATA_W-1:0] dq_w = dq_oe ? dq_h : dq_f;
   int                fails, check_count;
   fcd_row_s rows [12] = '{
      '{FCD_OP_RESET, 18'h0, 8'h0, 8'hF0, 1'b0}, '{FCD_OP_PROGRAM, 18'h30005, 8'h5A, 8'hA0, 1'b1},
      '{FCD_OP_CHIP_ERASE, 18'h0, 8'h0, 8'h10, 1'b0},
      '{FCD_OP_SECT_ERASE, 18'h20123, 8'h0, 8'h30, 1'b1},
      '{FCD_OP_SUSPEND, 18'h10777, 8'h0, 8'hB0, 1'b0},
      '{FCD_OP_RESUME, 18'h00ABC, 8'h0, 8'h30, 1'b0}, '{FCD_OP_ID_ENTER, 18'h0, 8'h0, 8'h90, 1'b0},
      '{FCD_OP_READ, 18'h0, 8'h0, MAKER_ID, 1'b0}, '{FCD_OP_READ, 18'h1, 8'h0, DEV_ID, 1'b0},
      '{FCD_OP_READ, 18'h2, 8'h0, 8'h00, 1'b0}, '{FCD_OP_RESET, 18'h0, 8'h0, 8'hF0, 1'b0},
      '{FCD_OP_READ, 18'h5, 8'h0, 8'h5A, 1'b0}};
   fcd_host i_fcd_host (.core_clk_i(core_clk), .srst_i(srst), .reg_addr_i(reg_addr),
      .reg_wdata_i(reg_wdata), .reg_wr_i(reg_wr), .reg_rd_i(reg_rd), .reg_rdata_o(reg_rdata),
      .flash_ce_n_o(ce_n), .flash_oe_n_o(oe_n), .flash_we_n_o(we_n), .flash_oe_hv_o(oe_hv),
      .flash_hv_addr_o(hv), .flash_addr_o(addr), .flash_dq_o(dq_h), .flash_dq_oe_o(dq_oe),
      .flash_dq_i(dq_w));
   fcd_flash_model #(.MAKER_ID(MAKER_ID), .DEV_ID(DEV_ID)) i_fcd_flash_model (.ce_n_i(ce_n),
      .oe_n_i(oe_n), .we_n_i(we_n), .oe_hv_i(oe_hv), .hv_addr_i(hv), .addr_i(addr),
      .dq_i(dq_w), .dq_o(dq_f), .cmd_o(cmd), .cadr_o(cadr), .bad_o(bad), .prot_o(prot));
////////////////////////////////////////////////////////////
   task automatic give_verdict();
      $display("comparisons %0d mismatches %0d", check_count, fails);
      if (fails == 0 && check_count > 0) begin
         $display("Regression OK");
      end else begin
         $display("Regression broken");
      end
      $finish;
   endtask : give_verdict
   task automatic check(input logic [31:0] seen, input logic [31:0] exp);
      check_count++;
      if (seen !== exp) begin
         fails++;
         $display("FAIL %0t seen %h expected %h", $time, seen, exp);
      end
   endtask : check
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_wdata <= d;
      reg_wr <= 1'b1;
      @(posedge core_clk);
      reg_wr <= 1'b0;
   endtask : wr
   task automatic rd(input logic [3:0] a, output logic [31:0] d);
      @(posedge core_clk);
      reg_addr <= a;
      reg_rd <= 1'b1;
      @(posedge core_clk);
      reg_rd <= 1'b0;
      #1 d = reg_rdata;
   endtask : rd
   // bounded poll of the busy flag
   task automatic idle();
      logic [31:0] s;
      s = 32'h1;
      for (int n = 0; n < 300 && s[0] !== 1'b0; n++) rd(REG_STATUS, s);
      if (s[0] !== 1'b0) begin
         fails++;
         give_verdict();
      end
   endtask : idle
   task automatic run(input logic [3:0] op, input logic [ADDR_W-1:0] a, input logic [7:0] d);
      wr(REG_ADDR, 32'(a));
      wr(REG_WDATA, 32'(d));
      wr(REG_CTRL, 32'(op));
      idle();
   endtask : run
////////////////////////////////////////////////////////////
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   initial begin
      srst = 1'b1;
      reg_wr = 1'b0;
      reg_rd = 1'b0;
      reg_addr = '0;
      reg_wdata = '0;
      repeat (10) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      check(32'({ce_n, oe_n, we_n, dq_oe}), 32'hE);
      foreach (rows[i]) begin
         run(rows[i].op, rows[i].a, rows[i].d);
         rd(REG_RDATA, v);
         if (rows[i].op == 4'(FCD_OP_READ)) check(v, 32'(rows[i].exp));
         else check(32'(cmd), 32'(rows[i].exp));
         if (rows[i].ca) check(32'(cadr), 32'(rows[i].a));
      end
      // pulse without unlock must be refused
      run(FCD_OP_PROT_PULSE, 18'h0, 8'h0);
      rd(REG_STATUS, v);
      check(32'({v[4], prot}), 32'h2);
      run(FCD_OP_PROT_UNLOCK, 18'h0, 8'h0);
      check(32'(cmd), 32'h20);
      run(FCD_OP_PROT_PULSE, 18'h0, 8'h0);
      check(32'(prot), 32'h1);
      run(FCD_OP_READ, 18'h0, 8'h0);
      rd(REG_STATUS, v);
      check(32'(v[4]), 32'h1);
      wr(REG_PINS, 32'h1);
      // verify read straight after the pulse
      run(FCD_OP_READ, 18'h2, 8'h0);
      rd(REG_RDATA, v);
      check(v, 32'h1);
      run(FCD_OP_READ, 18'h0, 8'h0);
      rd(REG_RDATA, v);
      check(v, 32'(MAKER_ID));
      wr(REG_PINS, 32'h5);
      run(FCD_OP_HV_PULSE, 18'h0, 8'h0);
      check(32'(prot), 32'h0);
      wr(REG_PINS, 32'h0);
      // second order while busy is refused
      wr(REG_CTRL, 32'(FCD_OP_PROGRAM));
      wr(REG_CTRL, 32'(FCD_OP_CHIP_ERASE));
      idle();
      rd(REG_STATUS, v);
      check(32'({v[4], cmd}), 32'h1A0);
      run(FCD_OP_SECT_ERASE, 18'h10000, 8'h0);
      run(FCD_OP_SECT_ADD, 18'h20000, 8'h0);
      check(32'(cadr), 32'h20000);
      repeat (3100) @(posedge core_clk);
      run(FCD_OP_SECT_ADD, 18'h30000, 8'h0);
      rd(REG_STATUS, v);
      check(32'({v[3], cadr}), 32'h60000);
      rd(4'hF, v);
      check(v, 32'h0);
      check(32'(bad), 32'h0);
      // reset in mid-sequence returns pins to idle
      wr(REG_CTRL, 32'(FCD_OP_PROGRAM));
      repeat (20) @(posedge core_clk);
      srst <= 1'b1;
      repeat (2) @(posedge core_clk);
      srst <= 1'b0;
      #1;
      check(32'({ce_n, oe_n, we_n, dq_oe}), 32'hE);
      give_verdict();
   end
endmodule : tb_top
`default_nettype wire
